/* File: core/jtg_pkg.sv */
package jtg_pkg;
    localparam int JTG_IR_LEN = 4;
    localparam int JTG_BSR_LEN = 115;
    localparam int JTG_ID_LEN = 32;
    localparam int JTG_CTL_CELLS = 3;
    localparam logic [3:0] JTG_IR_EXTEST = 4'h0;
    localparam logic [3:0] JTG_IR_SAMPLE = 4'h1;
    localparam logic [3:0] JTG_IR_BYPASS = 4'hf;
    localparam logic [3:0] JTG_IR_CAPTURE = 4'h1;
    localparam logic [3:0] JTG_IR_RESET = 4'hf;
    // Arbitrary identification value; bit 0 set as usual for an ID register
    localparam logic [31:0] JTG_ID_DEFAULT = 32'h0000_0001;

    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
        ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
        ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } jtg_state_t;

    typedef enum logic [1:0] {DR_BSR, DR_BYP, DR_ID} jtg_dr_sel_t;

    typedef struct packed {
        logic [JTG_IR_LEN-1:0] ir_sh;
        logic bypass;
        logic [JTG_ID_LEN-1:0] id_sh;
        logic [JTG_BSR_LEN-1:0] bsr_sh;
        logic [JTG_BSR_LEN-1:0] pad_hold;
        logic pad_ack;
    } jtg_rise_t;

    typedef struct packed {
        logic tdo;
        logic tdo_oe;
        logic [JTG_IR_LEN-1:0] ir_act;
        logic id_sel;
        logic test_mode;
        logic [JTG_BSR_LEN-1:0] bsr_upd;
        logic upd_tgl;
    } jtg_fall_t;

    typedef struct packed {
        logic [JTG_BSR_LEN-1:0] pad_s1;
        logic [JTG_BSR_LEN-1:0] pad_s2;
        logic [JTG_BSR_LEN-1:0] pad_snap;
        logic pad_req;
        logic upd_seen;
        logic [JTG_BSR_LEN-1:0] pin_out;
        logic test_mode;
    } jtg_sys_t;

    localparam jtg_fall_t JTG_FALL_RST = '{
        tdo: 1'b0, tdo_oe: 1'b0, ir_act: JTG_IR_RESET, id_sel: 1'b1,
        test_mode: 1'b0, bsr_upd: '0, upd_tgl: 1'b0
    };
endpackage : jtg_pkg

/* File: core/jtg_sync.sv */
`timescale 1ns/1ps
module jtg_sync
    import jtg_pkg::*;
(
    // Clock and clear
    input wire logic clock,
    input wire logic clr,
    // Level in and out
    input wire logic din,
    output logic dout
);
    logic [1:0] stage_reg;
    logic [1:0] stage_next;

    always_comb begin
        stage_next = {stage_reg[0], din};
        if (clr) begin
            stage_next = 2'h0;
        end
    end

    always_ff @(posedge clock) begin
        stage_reg <= stage_next;
    end

    assign dout = stage_reg[1];
endmodule : jtg_sync

/* File: core/jtg_tap_fsm.sv */
`timescale 1ns/1ps
module jtg_tap_fsm
    import jtg_pkg::*;
(
    // Test clock and reset
    input wire logic tck,
    input wire logic trst_n,
    // Mode select
    input wire logic tms,
    output jtg_state_t state
);
    jtg_state_t state_reg;
    jtg_state_t state_next;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RESET: state_next = tms ? ST_RESET : ST_IDLE;
            ST_IDLE: state_next = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: state_next = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_SEL_IR: state_next = tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_DR: state_next = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: state_next = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: state_next = tms ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: state_next = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: state_next = tms ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: state_next = tms ? ST_SEL_DR : ST_IDLE;
            ST_CAP_IR: state_next = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: state_next = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: state_next = tms ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: state_next = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: state_next = tms ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: state_next = tms ? ST_SEL_DR : ST_IDLE;
            default: state_next = ST_RESET;
        endcase
    end

    // TMS taken on the rising edge; TRST acts with no edge at all
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            state_reg <= ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign state = state_reg;
endmodule : jtg_tap_fsm

/* File: core/jtg_tap.sv */
`timescale 1ns/1ps
module jtg_tap
    import jtg_pkg::*;
#(
    parameter logic [JTG_ID_LEN-1:0] ID_VALUE = JTG_ID_DEFAULT
) (
    // System side
    input wire logic clock,
    input wire logic rst,
    // Test port, all but trst_n on the test clock
    input wire logic tck,
    input wire logic trst_n,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    // Pads seen by the boundary cells
    input wire logic [JTG_BSR_LEN-1:0] pad_in,
    // Boundary outputs toward the pads
    output logic [JTG_BSR_LEN-1:0] pin_out,
    output logic test_mode
);
    // Controller state
    jtg_state_t state;

    // Rising-edge test domain
    jtg_rise_t rise_reg;
    jtg_rise_t rise_next;

    // Falling-edge test domain
    jtg_fall_t fall_reg;
    jtg_fall_t fall_next;

    // System clock domain
    jtg_sys_t sys_reg;
    jtg_sys_t sys_next;

    // Crossed levels
    logic pad_req_t;
    logic pad_ack_s;
    logic upd_tgl_s;
    logic test_mode_s;

    // Selected data register
    jtg_dr_sel_t dr_sel;

    jtg_tap_fsm u_fsm (
        .tck(tck),
        .trst_n(trst_n),
        .tms(tms),
        .state(state)
    );

    // Reserved codes fall back on bypass so the chain stays one stage long
    always_comb begin
        if (fall_reg.id_sel) begin
            dr_sel = DR_ID;
        end else begin
            case (fall_reg.ir_act)
                JTG_IR_EXTEST: dr_sel = DR_BSR;
                JTG_IR_SAMPLE: dr_sel = DR_BSR;
                JTG_IR_BYPASS: dr_sel = DR_BYP;
                default: dr_sel = DR_BYP;
            endcase
        end
    end

    // Request toggle from the system side, into the test clock
    jtg_sync u_sync_req (
        .clock(tck),
        .clr(1'b0),
        .din(sys_reg.pad_req),
        .dout(pad_req_t)
    );

    // Acknowledge, update and mode back into the system clock
    jtg_sync u_sync_ack (
        .clock(clock),
        .clr(rst),
        .din(rise_reg.pad_ack),
        .dout(pad_ack_s)
    );

    jtg_sync u_sync_upd (
        .clock(clock),
        .clr(rst),
        .din(fall_reg.upd_tgl),
        .dout(upd_tgl_s)
    );

    jtg_sync u_sync_mode (
        .clock(clock),
        .clr(rst),
        .din(fall_reg.test_mode),
        .dout(test_mode_s)
    );

    // Rising edge: capture and shift
    always_comb begin
        rise_next = rise_reg;
        // Snapshot is stable until this side acknowledges it
        if (pad_req_t != rise_reg.pad_ack) begin
            rise_next.pad_hold = sys_reg.pad_snap;
            rise_next.pad_ack = pad_req_t;
        end
        case (state)
            ST_CAP_IR: begin
                rise_next.ir_sh = JTG_IR_CAPTURE;
            end
            ST_SHIFT_IR: begin
                rise_next.ir_sh = {tdi, rise_reg.ir_sh[JTG_IR_LEN-1:1]};
            end
            ST_CAP_DR: begin
                case (dr_sel)
                    DR_BSR: rise_next.bsr_sh = rise_reg.pad_hold;
                    DR_ID: rise_next.id_sh = ID_VALUE;
                    default: rise_next.bypass = 1'b0;
                endcase
            end
            ST_SHIFT_DR: begin
                case (dr_sel)
                    DR_BSR: begin
                        // Chain grows from TDI at bit 0 toward the top
                        rise_next.bsr_sh = {rise_reg.bsr_sh[JTG_BSR_LEN-2:0], tdi};
                    end
                    DR_ID: begin
                        rise_next.id_sh = {tdi, rise_reg.id_sh[JTG_ID_LEN-1:1]};
                    end
                    default: begin
                        rise_next.bypass = tdi;
                    end
                endcase
            end
            // Idle, pause, exit and select states leave every shift register alone
            default: begin
                rise_next.bypass = rise_reg.bypass;
            end
        endcase
    end

    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            rise_reg <= '0;
        end else begin
            rise_reg <= rise_next;
        end
    end

    // Falling edge: output data, instruction and update latches
    always_comb begin
        fall_next = fall_reg;
        fall_next.tdo_oe = (state == ST_SHIFT_DR) || (state == ST_SHIFT_IR);
        if (state == ST_SHIFT_IR) begin
            fall_next.tdo = rise_reg.ir_sh[0];
        end else begin
            case (dr_sel)
                DR_BSR: fall_next.tdo = rise_reg.bsr_sh[JTG_BSR_LEN-1];
                DR_ID: fall_next.tdo = rise_reg.id_sh[0];
                default: fall_next.tdo = rise_reg.bypass;
            endcase
        end
        case (state)
            ST_RESET: begin
                fall_next.id_sel = 1'b1;
                fall_next.ir_act = JTG_IR_RESET;
                fall_next.test_mode = 1'b0;
                // Toggle only once so the system side copies a settled word
                if (fall_reg.bsr_upd[JTG_BSR_LEN-1 -: JTG_CTL_CELLS] != '0) begin
                    fall_next.bsr_upd[JTG_BSR_LEN-1 -: JTG_CTL_CELLS] = '0;
                    fall_next.upd_tgl = ~fall_reg.upd_tgl;
                end
            end
            ST_UPD_IR: begin
                fall_next.ir_act = rise_reg.ir_sh;
                fall_next.id_sel = 1'b0;
                fall_next.test_mode = (rise_reg.ir_sh == JTG_IR_EXTEST);
            end
            ST_UPD_DR: begin
                if (dr_sel == DR_BSR) begin
                    fall_next.bsr_upd = rise_reg.bsr_sh;
                    fall_next.upd_tgl = ~fall_reg.upd_tgl;
                end
            end
            default: begin
                fall_next.ir_act = fall_reg.ir_act;
            end
        endcase
    end

    always_ff @(negedge tck or negedge trst_n) begin
        if (!trst_n) begin
            fall_reg <= JTG_FALL_RST;
        end else begin
            fall_reg <= fall_next;
        end
    end

    // System clock: pad sampling and output hand-off
    always_comb begin
        sys_next = sys_reg;
        sys_next.pad_s1 = pad_in;
        sys_next.pad_s2 = sys_reg.pad_s1;
        // New snapshot only once the previous one was taken
        if (pad_ack_s == sys_reg.pad_req) begin
            sys_next.pad_snap = sys_reg.pad_s2;
            sys_next.pad_req = ~sys_reg.pad_req;
        end
        // Update word holds for several test clocks, far longer than the sync delay
        if (upd_tgl_s != sys_reg.upd_seen) begin
            sys_next.pin_out = fall_reg.bsr_upd;
            sys_next.upd_seen = upd_tgl_s;
        end
        sys_next.test_mode = test_mode_s;
        if (rst) begin
            sys_next = '0;
        end
    end

    always_ff @(posedge clock) begin
        sys_reg <= sys_next;
    end

    assign tdo = fall_reg.tdo;
    assign tdo_oe = fall_reg.tdo_oe;
    assign pin_out = sys_reg.pin_out;
    assign test_mode = sys_reg.test_mode;
endmodule : jtg_tap

/* File: tb/jtg_tap_checker.sv */
`timescale 1ns/1ps
module jtg_tap_checker
    import jtg_pkg::*;
#(
    parameter logic [JTG_ID_LEN-1:0] ID_VALUE = JTG_ID_DEFAULT
) (
    // System side
    input wire logic clock,
    input wire logic rst,
    // Test port
    input wire logic tck,
    input wire logic trst_n,
    input wire logic tms,
    input wire logic tdo,
    input wire logic tdo_oe,
    // Boundary outputs
    input wire logic [JTG_BSR_LEN-1:0] pin_out,
    input wire logic test_mode
);
    sequence s_five_high; tms [*5]; endsequence
    sequence s_to_shift_dr; !tms ##1 tms ##1 !tms ##1 !tms; endsequence
    sequence s_to_shift_ir; !tms ##1 tms ##1 tms ##1 !tms ##1 !tms; endsequence
    sequence s_pause_back; tdo_oe && tms ##1 !tms [*2] ##1 tms ##1 !tms; endsequence
    property p_tdo_fall;
        @(posedge clock) disable iff (rst) (tck && $past(tck)) |-> $stable(tdo);
    endproperty
    a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved with tck high");
    property p_oe_fall;
        @(posedge clock) disable iff (rst) (tck && $past(tck)) |-> $stable(tdo_oe);
    endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("tdo_oe moved with tck high");
    property p_trst;
        @(posedge clock) disable iff (rst) !trst_n |-> !tdo_oe && !tdo;
    endproperty
    a_trst: assert property (p_trst) else $error("port active under test reset");
    property p_sys_rst;
        @(posedge clock) disable iff (1'b0) rst |=> pin_out == '0 && !test_mode;
    endproperty
    a_sys_rst: assert property (p_sys_rst) else $error("outputs not cleared by rst");
    // Only the walk from a known reset tells which register sits on tdo
    property p_id_default;
        @(posedge tck) disable iff (!trst_n)
            s_five_high ##1 s_to_shift_dr |=> tdo_oe && tdo == ID_VALUE[0];
    endproperty
    a_id_default: assert property (p_id_default) else $error("first data bit wrong");
    property p_ir_capture;
        @(posedge tck) disable iff (!trst_n) s_five_high ##1 s_to_shift_ir |=> tdo_oe && tdo;
    endproperty
    a_ir_capture: assert property (p_ir_capture) else $error("first ir bit wrong");
    property p_shift_hold;
        @(posedge tck) disable iff (!trst_n) tdo_oe && !tms |=> tdo_oe;
    endproperty
    a_shift_hold: assert property (p_shift_hold) else $error("shift left on tms low");
    property p_shift_leave;
        @(posedge tck) disable iff (!trst_n) tdo_oe && tms |=> !tdo_oe;
    endproperty
    a_shift_leave: assert property (p_shift_leave) else $error("shift kept on tms high");
    property p_pause;
        @(posedge tck) disable iff (!trst_n) s_pause_back |=> tdo_oe;
    endproperty
    a_pause: assert property (p_pause) else $error("pause did not return to shift");
endmodule : jtg_tap_checker

/* File: tb/jtg_master.sv */
`timescale 1ns/1ps
module jtg_master
    import jtg_pkg::*;
(
    // Lines toward the port
    output logic tck,
    output logic tms,
    output logic tdi,
    // Returned data
    input wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // Clock stands low between bits; tdo is taken at the rising edge
    task automatic bit_io(input logic m, input logic d, output logic q);
        #1 tms = m;
        tdi = d;
        #31 tck = 1'b1;
        q = tdo;
        #32 tck = 1'b0;
    endtask : bit_io
    // Non-data bits flip tdi so a stale value is never mistaken for data
    task automatic walk(input logic [7:0] path, input int n);
        logic q;
        for (int i = 0; i < n; i++) begin
            bit_io(path[i], ~tdi, q);
        end
    endtask : walk
    task automatic scan(input logic is_ir, input int n, input int pause_at,
                        input logic [127:0] din, output logic [127:0] dout);
        logic q;
        dout = '0;
        walk(is_ir ? 8'h06 : 8'h02, is_ir ? 5 : 4);
        for (int i = 0; i < n; i++) begin
            bit_io(i == n - 1 || i == pause_at, din[i], q);
            dout[i] = q;
            if (i == pause_at) begin
                walk(8'h04, 4);
            end
        end
        walk(8'h01, 2);
    endtask : scan
endmodule : jtg_master

/* File: tb/jtg_tap_bench.sv */
`timescale 1ns/1ps
`define CHK(what, exp, got) \
    begin \
        compares++; \
        if ((got) !== (exp)) begin \
            n_fail++; \
            $display("wrong value %s exp %0h got %0h", what, exp, got); \
        end \
    end
module jtg_tap_bench
    import jtg_pkg::*;
;
    logic clock;
    logic rst;
    logic trst_n;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;
    logic [JTG_BSR_LEN-1:0] pad_in;
    logic [JTG_BSR_LEN-1:0] pin_out;
    logic test_mode;
    logic [127:0] dout;
    logic [JTG_BSR_LEN-1:0] last_pins;
    int n_fail;
    int compares;
    jtg_tap i_jtg_tap (.clock(clock), .rst(rst), .tck(tck), .trst_n(trst_n), .tms(tms),
        .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pad_in(pad_in), .pin_out(pin_out),
        .test_mode(test_mode));
    jtg_master i_jtg_master (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    initial clock = 1'b0;
    always #12.5 clock = ~clock;
    task automatic print_verdict();
        if (n_fail == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
    task automatic wait_pins(input logic [JTG_BSR_LEN-1:0] want);
        int k;
        k = 0;
        while (pin_out !== want && k < 20) begin
            @(negedge clock);
            k++;
        end
        `CHK("pin_out", want, pin_out)
        if (k == 20) print_verdict();
    endtask : wait_pins
    // A pause index of -1 or below scans the code straight through
    task automatic load_ir(input logic [3:0] code, input int pause_at);
        i_jtg_master.scan(1'b1, 4, pause_at, {124'h0, code}, dout);
        `CHK("ir capture", 2'b01, dout[1:0])
        repeat (4) @(negedge clock);
    endtask : load_ir
    task automatic s_trst();
        load_ir(JTG_IR_SAMPLE, -1);
        @(negedge clock);
        trst_n = 1'b0;
        repeat (2) @(negedge clock);
        trst_n = 1'b1;
        for (int j = 0; j < 2; j++) begin
            if (j == 1) begin
                // Deselect the ID first so only the five-high walk can restore it
                load_ir(JTG_IR_BYPASS, -1);
                i_jtg_master.walk(8'h1f, 5);
            end
            i_jtg_master.scan(1'b0, 32, -1, 128'h0, dout);
            `CHK("idcode", JTG_ID_DEFAULT, dout[31:0])
        end
    endtask : s_trst
    task automatic s_bypass();
        logic [3:0] codes [4];
        logic [7:0] d;
        codes = '{4'hf, 4'h2, 4'h7, 4'he};
        d = 8'hb4;
        i_jtg_master.walk(8'h1f, 5);
        for (int j = 0; j < 4; j++) begin
            load_ir(codes[j], j - 2);
            i_jtg_master.scan(1'b0, 8, -1, {120'h0, d}, dout);
            `CHK("bypass", {d[6:0], 1'b0}, dout[7:0])
        end
    endtask : s_bypass
    // Pads settle over ten idle bits so the snapshot has crossed
    task automatic bsr_scan(input logic [114:0] p, input logic [127:0] d, input int pause_at);
        logic [127:0] want;
        want = '0;
        @(negedge clock);
        pad_in = p;
        i_jtg_master.walk(8'h00, 10);
        i_jtg_master.scan(1'b0, 116, pause_at, d, dout);
        for (int i = 0; i < 115; i++) begin
            want[i] = p[114 - i];
            last_pins[i] = d[115 - i];
        end
        want[115] = d[0];
        `CHK("bsr capture", want[115:0], dout[115:0])
        wait_pins(last_pins);
    endtask : bsr_scan
    task automatic s_bsr();
        load_ir(JTG_IR_SAMPLE, -1);
        `CHK("test_mode", 1'b0, test_mode)
        bsr_scan(115'h5_1234_5678_9abc_def0_1357_9bdf_0246, 128'hc3a5_0f1e_2d3c_4b5a_6978, -1);
        load_ir(JTG_IR_EXTEST, -1);
        `CHK("test_mode", 1'b1, test_mode)
        bsr_scan(115'h2_edcb_a987_6543_210f_eca8_6420_fdb9, 128'h9_1e2d_3c4b_5a69_7887, 40);
    endtask : s_bsr
    task automatic s_tlr();
        i_jtg_master.walk(8'h07, 3);
        wait_pins({3'b000, last_pins[111:0]});
        repeat (4) @(negedge clock);
        `CHK("test_mode", 1'b0, test_mode)
        i_jtg_master.scan(1'b0, 32, -1, 128'h0, dout);
        `CHK("idcode", JTG_ID_DEFAULT, dout[31:0])
    endtask : s_tlr
    initial begin
        rst = 1'b1;
        trst_n = 1'b0;
        pad_in = '0;
        last_pins = '0;
        n_fail = 0;
        compares = 0;
        repeat (10) @(negedge clock);
        rst = 1'b0;
        trst_n = 1'b1;
        s_trst();
        s_bypass();
        s_bsr();
        s_tlr();
        print_verdict();
    end
endmodule : jtg_tap_bench
bind jtg_tap jtg_tap_checker #(.ID_VALUE(ID_VALUE)) i_jtg_tap_checker (.clock(clock),
    .rst(rst), .tck(tck), .trst_n(trst_n), .tms(tms), .tdo(tdo), .tdo_oe(tdo_oe),
    .pin_out(pin_out), .test_mode(test_mode));
